// file: common/ubgt_pkg.sv
// constants, field layout and types for the baud generator and transmitter
// assumes a single synchronous clock domain; nothing here holds state
package ubgt_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // register addresses on the 3-bit host port
  localparam logic [2:0] ADDR_THR_LSR = 3'h0;
  localparam logic [2:0] ADDR_DLL = 3'h1;
  localparam logic [2:0] ADDR_DLM = 3'h2;
  localparam logic [2:0] ADDR_LCR = 3'h3;
  localparam logic [2:0] ADDR_FCR = 3'h4;
  localparam logic [2:0] ADDR_MCR = 3'h5;
  localparam logic [2:0] ADDR_ENHANCED_MODE_REG = 3'h6;
  localparam logic [2:0] ADDR_IER_ISR = 3'h7;

  //////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int FCR_FIFO_EN = 0;
  localparam int FCR_TRIG_LSB = 2;
  localparam int FCR_TRIG_MSB = 7;
  localparam int MCR_PRESCALE4 = 7;
  localparam int ENHANCED_MODE_REG_SAMPLE16 = 7;
  localparam int ENHANCED_MODE_REG_AUTO485 = 0;
  localparam int IER_RX_DATA = 0;
  localparam int IER_TX_EMPTY = 1;
  localparam int ISR_TX_EMPTY = 1;
  localparam int LSR_THR_EMPTY = 5;
  localparam int LSR_TX_EMPTY = 6;
  localparam int LCR_LEN_LSB = 0;
  localparam int LCR_LEN_MSB = 1;
  localparam int LCR_STOP2 = 2;
  localparam int LCR_PAR_EN = 3;
  localparam int LCR_PAR_EVEN = 4;

  //////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] DLL_RST = 8'h01;
  localparam logic [7:0] DLM_RST = 8'h00;
  localparam logic [7:0] LCR_RST = 8'h03;
  localparam logic [7:0] FCR_RST = 8'h00;
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [7:0] ENHANCED_MODE_REG_RST = 8'h00;
  localparam logic [7:0] IER_RST = 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // timing counts, in sampling ticks or input clocks
  localparam logic [3:0] TICK_LAST16 = 4'hf;
  localparam logic [3:0] TICK_LAST8 = 4'h7;
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
  localparam logic [2:0] DATA_LAST_BASE = 3'h4;
  localparam int FIFO_DEPTH = 64;
  localparam int DIV_W = 16;

  // one host access per cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ubgt_host_req_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_START = 5'b00010,
    S_DATA = 5'b00100,
    S_PARITY = 5'b01000,
    S_STOP = 5'b10000
  } ubgt_tx_state_t;

endpackage

// file: rtl/ubgt_rate_gen.sv
// prescaler and programmable divisor giving the sampling tick
// assumes clk_i is the oscillator clock shared by every channel
`timescale 1ns/1ps
`default_nettype none

module ubgt_rate_gen #(
  parameter int DIV_W = ubgt_pkg::DIV_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic div4_i,
  input wire logic [DIV_W-1:0] divisor_i,
  output logic tick_o
);

  if (DIV_W < 2)
  begin : g_bad_width
    $error("ubgt_rate_gen: DIV_W must be at least 2");
  end

  logic [1:0] pre_q;
  logic [DIV_W-1:0] cnt_q;
  logic tick_q;
  wire pre_tick;
  wire cnt_zero;
  wire tick_d;

  //////////////////////////////////////////////////////////////////////////////
  // divide by 1 or 4, then by the divisor; a zero divisor stops the ticks
  assign pre_tick = ce_i && (!div4_i || pre_q == ubgt_pkg::PRESCALE_LAST);
  assign cnt_zero = (cnt_q == '0);
  assign tick_d = pre_tick && cnt_zero && (divisor_i != '0);

  // prescale counter free runs so a ratio change takes effect within 4 clocks
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pre_q <= 2'h0;
    else if (ce_i)
      pre_q <= pre_q + 2'h1;
  end

  // down counter reloads divisor-1 on each tick; a zero divisor parks it at zero
  // so that the first tick after a new divisor is not delayed by a wrapped count
  wire [DIV_W-1:0] reload = (divisor_i == '0) ? '0 : divisor_i - DIV_W'(1);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_q <= '0;
    else if (pre_tick)
      cnt_q <= cnt_zero ? reload : cnt_q - DIV_W'(1);
  end

  // registered tick, one cycle wide
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tick_q <= 1'b0;
    else if (ce_i)
      tick_q <= tick_d;
  end

  assign tick_o = tick_q;

endmodule

`default_nettype wire

// file: rtl/ubgt_uart_tx.sv
// one channel: host registers, rate generator, transmit fifo, serializer, irq pin
// assumes host strobes are synchronous to clk_i and last one cycle each
//
// How it works
// - irq pin follows tx fifo or holding state
// - auto direction mode waits for transmitter empty, with the fifo off only
// - irq pin high when receive fifo above trigger, with fifo on and enable bit 0 set
// - one oscillator clock; bus needs no bit clock
// - own rate generator behind own prescaler
// - prescale bit 0 divides 1, 1 divides 4
// - sixteen bit divisor from two byte registers
// - divisor resets to one for maximum rate
// - sampling bit chooses 8x or 16x clock
// - sampling tick drives transmit and receive timing
// - each bit lasts 16 or 8 ticks
// - eight bit shift register fed from fifo
// - start, data, optional parity, then stop bits
// - least significant data bit goes first
// - holding register write only, feeds fifo
// - each holding write below capacity advances the write pointer
// - line status bits 5 and 6 report
// - bit 6 only when everything is empty
// - tx empty interrupt gated by enable bit 1
`timescale 1ns/1ps
`default_nettype none

module ubgt_uart_tx #(
  parameter int DEPTH = ubgt_pkg::FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire ubgt_pkg::ubgt_host_req_t host_req_i,
  output logic [7:0] rdata_o,
  input wire logic prescale_select_pin_i,
  input wire logic rx_above_trig_i,
  output logic sample_tick_o,
  output logic tx_serial_o,
  output logic irq_pin_chan_a_o
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;

  if (DEPTH < 2 || DEPTH > 64 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("ubgt_uart_tx: DEPTH must be a power of two from 2 to 64");
  end

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0] dll_q, dlm_q, lcr_q, fcr_q, mcr_q, enhanced_mode_reg_q, ier_q;
  logic sw_prescale_select_pin_q;
  logic [7:0] rdata_q;
  logic [7:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q, rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  ubgt_pkg::ubgt_tx_state_t state_q, state_d;
  logic [7:0] shreg_q;
  logic [2:0] bit_idx_q;
  logic [3:0] tick_cnt_q;
  logic par_q, stop_second_q, tx_q, tx_d, irq_q;
  logic [7:0] load_byte_q;
  logic [3:0] h_start_ticks_q;
  logic tick;

  //////////////////////////////////////////////////////////////////////////////
  // host decode; the bus is sampled on clk_i, no separate bus clock exists
  wire wr_en = ce_i && host_req_i.wr;
  wire rd_en = ce_i && host_req_i.rd;
  wire [2:0] addr = host_req_i.addr;
  wire [7:0] wdata = host_req_i.wdata;
  wire wr_thr = wr_en && addr == ubgt_pkg::ADDR_THR_LSR;
  wire wr_dll = wr_en && addr == ubgt_pkg::ADDR_DLL;
  wire wr_dlm = wr_en && addr == ubgt_pkg::ADDR_DLM;
  wire wr_lcr = wr_en && addr == ubgt_pkg::ADDR_LCR;
  wire wr_fcr = wr_en && addr == ubgt_pkg::ADDR_FCR;
  wire wr_mcr = wr_en && addr == ubgt_pkg::ADDR_MCR;
  wire wr_enhanced_mode_reg = wr_en && addr == ubgt_pkg::ADDR_ENHANCED_MODE_REG;
  wire wr_ier = wr_en && addr == ubgt_pkg::ADDR_IER_ISR;

  // configuration fields
  wire fifo_en = fcr_q[ubgt_pkg::FCR_FIFO_EN];
  wire auto485 = enhanced_mode_reg_q[ubgt_pkg::ENHANCED_MODE_REG_AUTO485];
  wire mode16 = enhanced_mode_reg_q[ubgt_pkg::ENHANCED_MODE_REG_SAMPLE16];
  wire div4 = sw_prescale_select_pin_q ? mcr_q[ubgt_pkg::MCR_PRESCALE4] : prescale_select_pin_i;
  wire [CNT_W-1:0] tx_trig = CNT_W'(fcr_q[ubgt_pkg::FCR_TRIG_MSB:ubgt_pkg::FCR_TRIG_LSB]);
  wire par_en = lcr_q[ubgt_pkg::LCR_PAR_EN];
  wire par_even = lcr_q[ubgt_pkg::LCR_PAR_EVEN];
  wire stop2 = lcr_q[ubgt_pkg::LCR_STOP2];
  wire [2:0] data_last = {1'b0, lcr_q[ubgt_pkg::LCR_LEN_MSB:ubgt_pkg::LCR_LEN_LSB]} + ubgt_pkg::DATA_LAST_BASE;

  //////////////////////////////////////////////////////////////////////////////
  // control registers; reset wins over the clock enable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dll_q <= ubgt_pkg::DLL_RST;
      dlm_q <= ubgt_pkg::DLM_RST;
      lcr_q <= ubgt_pkg::LCR_RST;
      fcr_q <= ubgt_pkg::FCR_RST;
      mcr_q <= ubgt_pkg::MCR_RST;
      enhanced_mode_reg_q <= ubgt_pkg::ENHANCED_MODE_REG_RST;
      ier_q <= ubgt_pkg::IER_RST;
    end
    else
    begin
      if (wr_dll) dll_q <= wdata;
      if (wr_dlm) dlm_q <= wdata;
      if (wr_lcr) lcr_q <= wdata;
      if (wr_fcr) fcr_q <= wdata;
      if (wr_mcr) mcr_q <= wdata;
      if (wr_enhanced_mode_reg) enhanced_mode_reg_q <= wdata;
      if (wr_ier) ier_q <= wdata;
    end
  end

  // the pin rules until software first touches the prescale register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sw_prescale_select_pin_q <= 1'b0;
    else if (wr_mcr)
      sw_prescale_select_pin_q <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // rate generator, one per channel, fed from the common clock
  ubgt_rate_gen #(
    .DIV_W(ubgt_pkg::DIV_W)
  ) u_rate_gen (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .div4_i(div4),
    .divisor_i({dlm_q, dll_q}),
    .tick_o(tick)
  );

  assign sample_tick_o = tick;

  //////////////////////////////////////////////////////////////////////////////
  // fifo; capacity one with the fifo off, so it doubles as the holding register
  wire [CNT_W-1:0] cap = fifo_en ? CNT_W'(DEPTH) : CNT_W'(1);
  wire push = wr_thr && (count_q < cap);
  wire fifo_empty = (count_q == '0);
  wire idle = (state_q == ubgt_pkg::S_IDLE);
  wire load = ce_i && tick && idle && !fifo_empty;
  wire flush = wr_fcr && (wdata[ubgt_pkg::FCR_FIFO_EN] != fifo_en);

  // storage, one flip-flop row per entry
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_ent
    always_ff @(posedge clk_i)
    begin
      if (push && wr_ptr_q == PTR_W'(i))
        mem_q[i] <= wdata;
    end
  end

  // pointers and level; toggling the fifo enable empties it
  always_ff @(posedge clk_i)
  begin
    if (rst_i || flush)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else if (ce_i)
    begin
      if (push) wr_ptr_q <= wr_ptr_q + PTR_W'(1);
      if (load) rd_ptr_q <= rd_ptr_q + PTR_W'(1);
      count_q <= count_q + CNT_W'(push) - CNT_W'(load);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // serializer state machine
  wire [3:0] bit_last = mode16 ? ubgt_pkg::TICK_LAST16 : ubgt_pkg::TICK_LAST8;
  wire bit_end = tick && tick_cnt_q == bit_last;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ubgt_pkg::S_IDLE: if (load) state_d = ubgt_pkg::S_START;
      ubgt_pkg::S_START: if (bit_end) state_d = ubgt_pkg::S_DATA;
      ubgt_pkg::S_DATA:
        if (bit_end && bit_idx_q == data_last)
          state_d = par_en ? ubgt_pkg::S_PARITY : ubgt_pkg::S_STOP;
      ubgt_pkg::S_PARITY: if (bit_end) state_d = ubgt_pkg::S_STOP;
      ubgt_pkg::S_STOP: if (bit_end && (!stop2 || stop_second_q)) state_d = ubgt_pkg::S_IDLE;
      default: state_d = ubgt_pkg::S_IDLE;
    endcase
  end

  // line level per state; parity bit makes the count of ones even or odd
  always_comb
  begin
    case (state_q)
      ubgt_pkg::S_START: tx_d = 1'b0;
      ubgt_pkg::S_DATA: tx_d = shreg_q[0];
      ubgt_pkg::S_PARITY: tx_d = par_even ? par_q : ~par_q;
      default: tx_d = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_q <= ubgt_pkg::S_IDLE;
    else if (ce_i)
      state_q <= state_d;
  end

  // shift register and bit timing; lcr changes mid-character are not guarded
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      shreg_q <= 8'h00;
      par_q <= 1'b0;
      bit_idx_q <= 3'h0;
      tick_cnt_q <= 4'h0;
      stop_second_q <= 1'b0;
    end
    else if (load)
    begin
      shreg_q <= mem_q[rd_ptr_q];
      par_q <= 1'b0;
      bit_idx_q <= 3'h0;
      tick_cnt_q <= 4'h0;
      stop_second_q <= 1'b0;
    end
    else if (ce_i && tick && !idle)
    begin
      tick_cnt_q <= bit_end ? 4'h0 : tick_cnt_q + 4'h1;
      if (bit_end && state_q == ubgt_pkg::S_DATA)
      begin
        shreg_q <= {1'b0, shreg_q[7:1]};
        par_q <= par_q ^ shreg_q[0];
        bit_idx_q <= bit_idx_q + 3'h1;
      end
      if (bit_end && state_q == ubgt_pkg::S_STOP)
        stop_second_q <= 1'b1;
    end
  end

  // line output is registered, so it trails the state by one clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tx_q <= 1'b1;
    else if (ce_i)
      tx_q <= tx_d;
  end

  assign tx_serial_o = tx_q;

  //////////////////////////////////////////////////////////////////////////////
  // status and interrupt pin
  wire lsr_thre = fifo_empty;
  wire lsr_temt = fifo_empty && idle;
  wire tx_below = (count_q <= tx_trig);
  wire tx_cond = fifo_en ? tx_below : (fifo_empty && (!auto485 || idle));
  wire tx_irq = ier_q[ubgt_pkg::IER_TX_EMPTY] && tx_cond;
  wire rx_irq = ier_q[ubgt_pkg::IER_RX_DATA] && fifo_en && rx_above_trig_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_q <= 1'b0;
    else if (ce_i)
      irq_q <= tx_irq || rx_irq;
  end

  assign irq_pin_chan_a_o = irq_q;

  // read words; the holding register reads back as line status instead
  wire [7:0] lsr_word = {1'b0, lsr_temt, lsr_thre, 5'h00};
  wire [7:0] isr_word = {6'h00, tx_irq, 1'b0};
  wire [7:0] rd_words [8];
  assign rd_words[ubgt_pkg::ADDR_THR_LSR] = lsr_word;
  assign rd_words[ubgt_pkg::ADDR_DLL] = dll_q;
  assign rd_words[ubgt_pkg::ADDR_DLM] = dlm_q;
  assign rd_words[ubgt_pkg::ADDR_LCR] = lcr_q;
  assign rd_words[ubgt_pkg::ADDR_FCR] = fcr_q;
  assign rd_words[ubgt_pkg::ADDR_MCR] = mcr_q;
  assign rd_words[ubgt_pkg::ADDR_ENHANCED_MODE_REG] = enhanced_mode_reg_q;
  assign rd_words[ubgt_pkg::ADDR_IER_ISR] = isr_word;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_q <= 8'h00;
    else if (rd_en)
      rdata_q <= rd_words[addr];
  end

  assign rdata_o = rdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // helper state for the checks below
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      load_byte_q <= 8'h00;
    else if (load)
      load_byte_q <= mem_q[rd_ptr_q];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_q != ubgt_pkg::S_START)
      h_start_ticks_q <= 4'h0;
    else if (ce_i && tick)
      h_start_ticks_q <= h_start_ticks_q + 4'h1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_irq_fifo_empty;
    (ce_i && fifo_en && ier_q[ubgt_pkg::IER_TX_EMPTY] && fifo_empty) |=> irq_pin_chan_a_o;
  endproperty
  a_irq_fifo_empty: assert property (p_irq_fifo_empty) else $error("irq low with empty tx fifo");

  property p_irq_auto485_busy;
    (ce_i && !fifo_en && auto485 && !idle) |=> !irq_pin_chan_a_o;
  endproperty
  a_irq_auto485_busy: assert property (p_irq_auto485_busy) else $error("irq high while shifting");

  property p_irq_rx;
    (ce_i && fifo_en && ier_q[ubgt_pkg::IER_RX_DATA] && rx_above_trig_i) |=> irq_pin_chan_a_o;
  endproperty
  a_irq_rx: assert property (p_irq_rx) else $error("irq low with rx above trigger");

  property p_div_reset;
    @(posedge clk_i) disable iff (1'b0) rst_i |=> (dll_q == 8'h01 && dlm_q == 8'h00);
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("divisor not one after reset");

  property p_start_len;
    (ce_i && state_q == ubgt_pkg::S_START && state_d == ubgt_pkg::S_DATA) |-> h_start_ticks_q == bit_last;
  endproperty
  a_start_len: assert property (p_start_len) else $error("start bit length wrong");

  property p_lsb_first;
    $rose(state_q == ubgt_pkg::S_DATA) |=> tx_serial_o == load_byte_q[0];
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("first data bit not bit 0");

  property p_wr_advance;
    push |=> wr_ptr_q == $past(wr_ptr_q) + PTR_W'(1);
  endproperty
  a_wr_advance: assert property (p_wr_advance) else $error("write pointer did not advance");

  property p_temt;
    lsr_word[ubgt_pkg::LSR_TX_EMPTY] |-> (lsr_word[ubgt_pkg::LSR_THR_EMPTY] && state_q == ubgt_pkg::S_IDLE);
  endproperty
  a_temt: assert property (p_temt) else $error("tx empty with work pending");

  property p_stop_after_data;
    $rose(state_q == ubgt_pkg::S_STOP) |-> $past(state_q == ubgt_pkg::S_DATA || state_q == ubgt_pkg::S_PARITY);
  endproperty
  a_stop_after_data: assert property (p_stop_after_data) else $error("stop without data");

  property p_load_start;
    load |=> (state_q == ubgt_pkg::S_START && count_q == $past(count_q) + CNT_W'($past(push)) - CNT_W'(1));
  endproperty
  a_load_start: assert property (p_load_start) else $error("load did not start a frame");

  property p_prescale_sw;
    sw_prescale_select_pin_q |-> div4 == mcr_q[ubgt_pkg::MCR_PRESCALE4];
  endproperty
  a_prescale_sw: assert property (p_prescale_sw) else $error("prescale pin not overridden");

  property p_cap;
    count_q <= cap;
  endproperty
  a_cap: assert property (p_cap) else $error("fifo over capacity");

  c_parity: cover property ($rose(state_q == ubgt_pkg::S_PARITY));
  c_full: cover property (fifo_en && count_q == CNT_W'(DEPTH));
  c_two_stop: cover property (state_q == ubgt_pkg::S_STOP && stop_second_q);
  c_irq_485: cover property (auto485 && $rose(irq_pin_chan_a_o));

endmodule

`default_nettype wire

// file: verif/ubgt_host_model.sv
// host model for the register port: one strobe per access
// assumes strobes are sampled on the rising clock edge after reset
`timescale 1ns/1ps
`default_nettype none

module ubgt_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output var ubgt_pkg::ubgt_host_req_t req_o
);
  // idle bus from time zero
  initial req_o = '0;

  // divisor from oscillator, prescale ratio, data rate and oversampling
  function automatic logic [15:0] calc_div(input int f, input int pre, input int rate, input int mult);
    return 16'(f / pre / (rate * mult));
  endfunction

  // strobe for one edge, released on the next
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(posedge clk_i);
    req_o <= '0;
  endtask

  // data taken two edges late: it holds until the next read anyway
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    req_o <= '0;
    repeat (2) @(posedge clk_i);
    d = rdata_i;
  endtask
endmodule

`default_nettype wire

// file: verif/testbench.sv
// self-checking bench for one transmit channel and its rate generator
// assumes the package and host model are compiled first; 200 MHz clock
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic pin_q = 1'h1;
  logic rx_above_q = 1'h0;
  logic [7:0] rdata;
  logic tick;
  logic ser;
  logic irq;
  logic [7:0] v;
  ubgt_pkg::ubgt_host_req_t req;
  int error_cnt = 0;
  int tests_run = 0;

  // free-running clock
  always #2.5 clk_i = ~clk_i;

  // clock enable tied high: freezing is not exercised here
  ubgt_uart_tx u_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(1'h1),
    .host_req_i(req),
    .rdata_o(rdata),
    .prescale_select_pin_i(pin_q),
    .rx_above_trig_i(rx_above_q),
    .sample_tick_o(tick),
    .tx_serial_o(ser),
    .irq_pin_chan_a_o(irq)
  );

  ubgt_host_model u_host (
    .clk_i(clk_i),
    .rdata_i(rdata),
    .req_o(req)
  );

  ////////////////////////////////////////////////////////////
  // reporting and waits
  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic timeout(input string what);
    error_cnt++;
    $display("CHECK FAILED %s expected event seen timeout", what);
    print_verdict();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // edges up to the next tick; old schedule is skipped twice
  task automatic tick_gap(input int exp, input string what);
    int n;
    for (int k = 0; k < 3; k++)
    begin
      n = 0;
      do
      begin
        @(posedge clk_i);
        n++;
        if (n > 2000)
          timeout(what);
      end while (tick !== 1'h1);
    end
    check(what, 16'(n), 16'(exp));
  endtask

  // catch the start edge, then judge each bit in its middle
  task automatic rx_frame(input logic [7:0] d, input int nb, input int bl, input logic par, input logic two);
    int n;
    logic p;
    n = 0;
    p = 1'h0;
    while (ser !== 1'h0)
    begin
      @(posedge clk_i);
      n++;
      if (n > 3000)
        timeout("start bit");
    end
    cyc(bl / 2);
    check("start bit", ser, 1'h0);
    for (int i = 0; i < nb; i++)
    begin
      cyc(bl);
      check("data bit", ser, d[i]);
      p = p ^ d[i];
    end
    if (par)
    begin
      cyc(bl);
      check("parity bit", ser, p);
    end
    cyc(bl);
    check("stop bit", ser, 1'h1);
    if (two)
    begin
      cyc(bl);
      check("second stop", ser, 1'h1);
    end
  endtask

  ////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset_rate();
    logic [15:0] dv;
    u_host.rd(ubgt_pkg::ADDR_THR_LSR, v);
    check("lsr at reset", v, 8'h60);
    check("irq at reset", irq, 1'h0);
    tick_gap(4, "pin divide by 4");
    u_host.wr(ubgt_pkg::ADDR_MCR, 8'h00);
    tick_gap(1, "mcr overrides pin");
    dv = u_host.calc_div(200000000, 4, 1562500, 8);
    u_host.wr(ubgt_pkg::ADDR_DLL, dv[7:0]);
    u_host.wr(ubgt_pkg::ADDR_MCR, 8'h80);
    tick_gap(16, "divisor 4 after divide by 4");
    u_host.wr(ubgt_pkg::ADDR_DLL, 8'h00);
    u_host.wr(ubgt_pkg::ADDR_DLM, 8'h01);
    u_host.wr(ubgt_pkg::ADDR_MCR, 8'h00);
    tick_gap(256, "divisor high byte");
    u_host.wr(ubgt_pkg::ADDR_DLM, 8'h00);
    u_host.wr(ubgt_pkg::ADDR_DLL, 8'h01);
  endtask

  // every length at 8x, then parity and two stops at 16x
  task automatic t_frames();
    for (int len = 0; len < 4; len++)
    begin
      u_host.wr(ubgt_pkg::ADDR_LCR, 8'(len));
      u_host.wr(ubgt_pkg::ADDR_THR_LSR, 8'ha5);
      rx_frame(8'ha5, 5 + len, 8, 1'h0, 1'h0);
      cyc(8);
    end
    u_host.wr(ubgt_pkg::ADDR_LCR, 8'h1f);
    u_host.wr(ubgt_pkg::ADDR_ENHANCED_MODE_REG, 8'h80);
    u_host.wr(ubgt_pkg::ADDR_THR_LSR, 8'h3d);
    rx_frame(8'h3d, 8, 16, 1'h1, 1'h1);
    cyc(16);
    u_host.wr(ubgt_pkg::ADDR_LCR, 8'h03);
    u_host.wr(ubgt_pkg::ADDR_ENHANCED_MODE_REG, 8'h00);
  endtask

  // holding mode: auto direction keeps irq low until the shifter empties
  task automatic t_direction();
    u_host.wr(ubgt_pkg::ADDR_IER_ISR, 8'h02);
    for (int m = 0; m < 2; m++)
    begin
      u_host.wr(ubgt_pkg::ADDR_DLL, 8'h00);
      u_host.wr(ubgt_pkg::ADDR_ENHANCED_MODE_REG, 8'(m));
      u_host.wr(ubgt_pkg::ADDR_THR_LSR, 8'h55);
      cyc(3);
      check("irq byte held", irq, 1'h0);
      u_host.wr(ubgt_pkg::ADDR_DLL, 8'h01);
      rx_frame(8'h55, 8, 8, 1'h0, 1'h0);
      check("irq during stop", irq, 1'(m == 0));
      cyc(16);
      check("irq all empty", irq, 1'h1);
    end
    u_host.wr(ubgt_pkg::ADDR_ENHANCED_MODE_REG, 8'h00);
  endtask

  // fill past depth with ticks stopped, then drain in order
  task automatic t_fifo();
    logic seen_low;
    u_host.wr(ubgt_pkg::ADDR_DLL, 8'h00);
    u_host.wr(ubgt_pkg::ADDR_FCR, 8'h09);
    for (int k = 0; k < 65; k++)
    begin
      u_host.wr(ubgt_pkg::ADDR_THR_LSR, 8'(k));
      cyc(3);
      check("irq vs trigger 2", irq, 1'(k < 2));
    end
    u_host.rd(ubgt_pkg::ADDR_THR_LSR, v);
    check("lsr while full", v, 8'h00);
    u_host.wr(ubgt_pkg::ADDR_DLL, 8'h01);
    for (int k = 0; k < 64; k++)
      rx_frame(8'(k), 8, 8, 1'h0, 1'h0);
    cyc(8);
    u_host.rd(ubgt_pkg::ADDR_THR_LSR, v);
    check("lsr after drain", v, 8'h60);
    check("irq after drain", irq, 1'h1);
    seen_low = 1'h0;
    for (int k = 0; k < 100; k++)
    begin
      @(posedge clk_i);
      seen_low = seen_low | (ser !== 1'h1);
    end
    check("write to full fifo dropped", seen_low, 1'h0);
    u_host.wr(ubgt_pkg::ADDR_IER_ISR, 8'h00);
    cyc(3);
    check("irq masked", irq, 1'h0);
  endtask

  // receiver level reaches the pin only with its enable set
  task automatic t_rx();
    u_host.wr(ubgt_pkg::ADDR_IER_ISR, 8'h01);
    @(posedge clk_i);
    rx_above_q <= 1'h1;
    cyc(3);
    check("irq rx above", irq, 1'h1);
    @(posedge clk_i);
    rx_above_q <= 1'h0;
    cyc(3);
    check("irq rx below", irq, 1'h0);
  endtask

  // main sequence
  initial
  begin
    cyc(12);
    rst_i <= 1'h0;
    t_reset_rate();
    t_frames();
    t_direction();
    t_fifo();
    t_rx();
    print_verdict();
  end
endmodule

`default_nettype wire
